// ### hw/vc0cap_register.sv
// Purpose: read-only vc0 resource capability register of the bridge
// Assumes: one request per cycle, answered the cycle after it is taken
// Notes:   writes are acknowledged and dropped; the value is a constant
`include "vc0cap_consts.svh"

module vc0cap_register (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // configuration access
  input  wire vc0cap_pkg::vc0cap_req_t req,
  output vc0cap_pkg::vc0cap_rsp_t   rsp
);

  // ----------------------------------------------------------------
  // overview
  // ----------------------------------------------------------------
  // every configuration access is answered one cycle after it is taken.
  // only a read of offset 160h returns data; every other access answers
  // with zero data, so software probing nearby offsets sees a clean miss.
  // nothing here is writable, so there is no write enable and no storage.
  // limitation: the address compare is the full 12 bits, so a byte or
  // word access that does not start at 160h is treated as a miss.
  // the answer is the only state; reset clears it to all zero.

  // ----------------------------------------------------------------
  // constant capability value
  // ----------------------------------------------------------------
  vc0cap_pkg::vc0cap_reg_t capValue;
  logic                    hit;

  // bit map of the word handed to software:
  //   31:24 table location, zero as no port table exists
  //   23    reserved
  //   22:16 slot limit, zero as time-slot arbitration is absent
  //   15    snoop refusal, zero as the bridge is no root port
  //   14    advanced-packet-only flag, zero
  //   13:8  reserved
  //   7:0   scheme mask: bit 0 fixed round-robin, bits 1-3 weighted 32/64/128,
  //         bit 4 time-based 128, bit 5 weighted 256, bits 6-7 reserved
  // fields are tied, so no write path can ever reach them
  always_comb begin
    capValue.arbTableLocation   = `VC0CAP_TABLE_LOC;
    capValue.rsvdHigh           = 1'b0;
    capValue.slotLimit          = `VC0CAP_SLOT_LIMIT;
    capValue.snoopRefusal       = 1'b0;
    capValue.advancedPacketOnly = 1'b0;
    capValue.rsvdLow            = 6'h00;
    capValue.portArbiterSchemes = `VC0CAP_SCHEMES;
  end

  assign hit = (req.addr == `VC0CAP_OFFSET);

  // ----------------------------------------------------------------
  // per-bit tie-off check
  // ----------------------------------------------------------------
  // each bit is compared on its own so a misplaced struct field names the
  // bit position; the reset word is the only value the register ever has
  localparam logic [31:0] CAP_WORD = `VC0CAP_RESET;
  for (genvar bitIdx = 0; bitIdx < 32; bitIdx++) begin : g_cap_bit
    a_cap_bit_tie: assert property (@(posedge clk_sys) disable iff (rst)
      capValue[bitIdx] == CAP_WORD[bitIdx])
      else $error("capability bit tied to wrong level");
  end

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  logic anyReq;
  logic readHit;
  logic writeHit;
  logic writeOnly;

  // a combined rd and wr is served as a read, so only a pure write counts as one
  assign anyReq    = req.rd | req.wr;
  assign readHit   = req.rd & hit;
  assign writeHit  = req.wr & hit;
  assign writeOnly = req.wr & ~req.rd;

  // ----------------------------------------------------------------
  // answer path
  // ----------------------------------------------------------------
  vc0cap_pkg::vc0cap_rsp_t next_rsp;

  // registered answer keeps rdata on flip-flops; the cost is one cycle of
  // latency on every access, hit or miss. misses still answer, so a probe
  // of a neighbouring offset never leaves the requester waiting
  // writes acked like reads but never stored
  always_comb begin
    next_rsp.ack   = req.rd | req.wr;
    next_rsp.hit   = (req.rd | req.wr) & hit;
    next_rsp.rdata = `VC0CAP_UNMAPPED;
    if (req.rd && hit) begin
      next_rsp.rdata = capValue;
    end
  end

  // async clear gives an all-zero answer while reset is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_read_value: assert property (@(posedge clk_sys) disable iff (rst)
    (req.rd && hit) |=> (rsp.rdata == `VC0CAP_RESET && rsp.ack))
    else $error("capability read returned wrong value");
  a_table_loc: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> rsp.rdata[31:24] == 8'h00)
    else $error("table location not zero");
  a_slot_limit: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> rsp.rdata[22:16] == 7'h00)
    else $error("slot limit not zero");
  a_snoop_bit: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> !rsp.rdata[15])
    else $error("snoop refusal bit set");
  a_adv_bit: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> !rsp.rdata[14])
    else $error("advanced packet bit set");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> (rsp.rdata[23] == 1'b0 && rsp.rdata[13:8] == 6'h00))
    else $error("reserved bits not zero");
  a_scheme_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> $onehot(rsp.rdata[7:0]))
    else $error("scheme mask not one-hot");
  a_scheme_value: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && hit) |-> rsp.rdata[7:0] == 8'h01)
    else $error("scheme mask not fixed round-robin");
  a_write_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (req.wr && hit) ##1 (req.rd && hit) |=> (rsp.rdata == `VC0CAP_RESET))
    else $error("write altered capability value");
  a_write_acked: assert property (@(posedge clk_sys) disable iff (rst)
    writeOnly |=> rsp.ack && rsp.rdata == `VC0CAP_UNMAPPED)
    else $error("write not acknowledged cleanly");

  // ----------------------------------------------------------------
  // answer shape checks
  // ----------------------------------------------------------------
  // a hit sets both ack and hit in the answer
  a_hit_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (anyReq && hit) |=> (rsp.ack && rsp.hit))
    else $error("hit not flagged in answer");
  // a miss still answers, with no hit and no data
  a_miss_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (anyReq && !hit) |=> (rsp.ack && !rsp.hit && rsp.rdata == `VC0CAP_UNMAPPED))
    else $error("miss answered wrongly");
  // an idle cycle leaves the answer quiet
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !anyReq |=> (!rsp.ack && !rsp.hit && rsp.rdata == `VC0CAP_UNMAPPED))
    else $error("answer without request");
  // ack only ever follows a request
  a_ack_source: assert property (@(posedge clk_sys) disable iff (rst)
    rsp.ack |-> $past(anyReq))
    else $error("ack without a request");

  // read and write together is served as a read
  a_both_as_read: assert property (@(posedge clk_sys) disable iff (rst)
    (readHit && req.wr) |=> (rsp.rdata == `VC0CAP_RESET))
    else $error("combined access not served as read");
  // a pure write hit is flagged but returns no data
  a_write_no_data: assert property (@(posedge clk_sys) disable iff (rst)
    (writeHit && !req.rd) |=> (rsp.hit && rsp.rdata == `VC0CAP_UNMAPPED))
    else $error("write hit returned data");
  // data appears only after a read hit
  a_rdata_only_read: assert property (@(posedge clk_sys) disable iff (rst)
    (rsp.rdata != `VC0CAP_UNMAPPED) |-> $past(readHit))
    else $error("data without read hit");
  // hit never stands without ack
  a_hit_needs_ack: assert property (@(posedge clk_sys) disable iff (rst)
    rsp.hit |-> rsp.ack)
    else $error("hit without ack");

  // back-to-back reads see the same word
  a_stable_value: assert property (@(posedge clk_sys) disable iff (rst)
    readHit ##1 readHit |=> $stable(rsp.rdata))
    else $error("capability value changed between reads");
  // reserved scheme bits stay clear
  a_scheme_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    $past(readHit) |-> (rsp.rdata[7:6] == 2'h0))
    else $error("reserved scheme bits set");
  // hit flag only for an access to the register offset
  a_hit_source: assert property (@(posedge clk_sys) disable iff (rst)
    rsp.hit |-> $past(anyReq && hit))
    else $error("hit flagged for another offset");
  // an offset not on the dword boundary never hits
  a_addr_exact: assert property (@(posedge clk_sys) disable iff (rst)
    (anyReq && req.addr[1:0] != 2'h0) |=> !rsp.hit)
    else $error("unaligned offset hit");

  // ----------------------------------------------------------------
  // per-bit answer check
  // ----------------------------------------------------------------
  // only bit 0 can ever be set in any answer, so every other bit of
  // rdata is watched on its own against stray logic
  for (genvar ansIdx = 1; ansIdx < 32; ansIdx++) begin : g_ans_bit
    a_ans_bit_zero: assert property (@(posedge clk_sys) disable iff (rst)
      !rsp.rdata[ansIdx])
      else $error("answer bit other than bit 0 set");
  end

  c_read_hit:   cover property (@(posedge clk_sys) disable iff (rst) req.rd && hit);
  c_write_hit:  cover property (@(posedge clk_sys) disable iff (rst) req.wr && hit);
  c_write_read: cover property (@(posedge clk_sys) disable iff (rst) (req.wr && hit) ##1 (req.rd && hit));
  c_miss:       cover property (@(posedge clk_sys) disable iff (rst) req.rd && !hit);
  c_both_rw:    cover property (@(posedge clk_sys) disable iff (rst) readHit && req.wr);

endmodule

// ### pkg/vc0cap_consts.svh
// Purpose: constants for the vc0 resource capability register
// Assumes: byte-addressed extended configuration space, dword access
// Notes:   offset, address width and the table, slot and scheme field values of the block; field positions are set by the package struct
`ifndef VC0CAP_CONSTS_SVH
`define VC0CAP_CONSTS_SVH

// ----------------------------------------------------------------
// register placement
// ----------------------------------------------------------------
`define VC0CAP_OFFSET        12'h160
`define VC0CAP_RESET         32'h0000_0001

// ----------------------------------------------------------------
// field values
// ----------------------------------------------------------------
`define VC0CAP_TABLE_LOC     8'h00
`define VC0CAP_SLOT_LIMIT    7'h00
`define VC0CAP_SCHEMES       8'h01
`define VC0CAP_ADDR_W        12
`define VC0CAP_UNMAPPED      32'h0000_0000

`endif

// ### pkg/vc0cap_pkg.sv
// Purpose: types for the vc0 resource capability register
// Assumes: constants come from vc0cap_consts.svh
// Notes:   field layout follows the register bit map, msb first
`include "vc0cap_consts.svh"
package vc0cap_pkg;

  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] arbTableLocation;   // 31:24
    logic       rsvdHigh;           // 23
    logic [6:0] slotLimit;          // 22:16
    logic       snoopRefusal;       // 15
    logic       advancedPacketOnly; // 14
    logic [5:0] rsvdLow;            // 13:8
    logic [7:0] portArbiterSchemes; // 7:0
  } vc0cap_reg_t;

  // ----------------------------------------------------------------
  // configuration request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      rd;
    logic                      wr;
    logic [`VC0CAP_ADDR_W-1:0] addr;
    logic [31:0]               wdata;
  } vc0cap_req_t;

  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } vc0cap_rsp_t;

endpackage

// ### bench/vc0cap_register_test.sv
// Purpose: self-checking bench for the vc0 resource capability register
// Assumes: one request per cycle, answer one cycle after it is taken
// Notes:   random traffic from a fixed seed mixed with hand-made corner cases
`include "vc0cap_consts.svh"
module vc0cap_register_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // clock, reset and design
  // ----------------------------------------------------------------
  logic                    clk_sys     = 1'b0;
  logic                    rst         = 1'b1;
  vc0cap_pkg::vc0cap_req_t req         = '0;
  vc0cap_pkg::vc0cap_rsp_t rsp;
  vc0cap_pkg::vc0cap_reg_t fields;
  int                      mismatches  = 0;
  int                      comparisons = 0;
  int                      seed        = 74;
  always #5 clk_sys = ~clk_sys;
  vc0cap_register vc0cap_register_inst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req     (req),
    .rsp     (rsp)
  );
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] expv, input logic [33:0] seen);
    comparisons++;
    if (seen !== expv) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask
  // expected answer from the request alone; data only for a read hit
  function automatic logic [33:0] expect_rsp(input logic rd, input logic wr, input logic [11:0] addr);
    logic hit;
    hit = (rd | wr) && (addr == `VC0CAP_OFFSET);
    return {rd | wr, hit, (rd && hit) ? `VC0CAP_RESET : `VC0CAP_UNMAPPED};
  endfunction
  // one request held for one edge; left standing so requests run back to back
  task automatic access(input logic rd, input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    req <= '{rd: rd, wr: wr, addr: addr, wdata: wdata};
    @(posedge clk_sys);
    #1;
    check("rsp", expect_rsp(rd, wr, addr), rsp);
    fields = rsp.rdata;
    if (rd && addr == 12'h160) begin
      check("arbTableLocation", 34'(fields.arbTableLocation), 34'h0);
      check("slotLimit", 34'(fields.slotLimit), 34'h0);
      check("snoopRefusal", 34'(fields.snoopRefusal), 34'h0);
      check("advancedPacketOnly", 34'(fields.advancedPacketOnly), 34'h0);
      check("reserved", 34'({fields.rsvdHigh, fields.rsvdLow}), 34'h0);
      check("portArbiterSchemes", 34'(fields.portArbiterSchemes), 34'h1);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk_sys);
    #1;
    check("rspInReset", 34'h0, rsp);
    rst <= 1'b0;
    access(1'b1, 1'b0, 12'h160, 32'h0000_0000);
    access(1'b0, 1'b1, 12'h160, 32'hFFFF_FFFF);
    access(1'b1, 1'b0, 12'h160, 32'h0000_0000);
    access(1'b1, 1'b1, 12'h160, 32'hFFFF_FFFF);
    access(1'b1, 1'b0, 12'h161, 32'h0000_0000);
    access(1'b1, 1'b0, 12'h15C, 32'h0000_0000);
    access(1'b1, 1'b0, 12'h164, 32'h0000_0000);
    // random mix, half aimed at the register itself
    repeat (300) begin
      r = $random(seed);
      access(r[0], r[1], r[2] ? 12'h160 : r[14:3], $random(seed));
    end
    // reset in mid-run must bring back the constant value
    access(1'b0, 1'b0, 12'h000, 32'h0000_0000);
    rst <= 1'b1;
    #1;
    check("rspMidReset", 34'h0, rsp);
    @(posedge clk_sys);
    #1;
    rst <= 1'b0;
    access(1'b1, 1'b0, 12'h160, 32'h0000_0000);
    access(1'b0, 1'b0, 12'h000, 32'h0000_0000);
    give_verdict();
  end
  // hang guard, well beyond the few thousand ns the tests need
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule
